// >>> common/lmp_pkg.sv
package lmp_pkg;

   localparam int unsigned REF_CLK_MHZ   = 40;
   localparam int unsigned ADDR_W        = 17;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned EE_W          = 16;

   // Access timing, in ns as chosen, cycles derived at the ref_clk rate
   localparam int unsigned SETUP_NS      = 50;
   localparam int unsigned STROBE_NS     = 100;
   localparam int unsigned HOLD_NS       = 50;
   localparam int unsigned EE_HALF_NS    = 1000;
   localparam int unsigned SETUP_CYC     = (SETUP_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned STROBE_CYC    = (STROBE_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned HOLD_CYC      = (HOLD_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned EE_HALF_CYC   = (EE_HALF_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W         = 6;

   // Shared address pin positions
   localparam int unsigned PIN_HOST_TYPE = 0;
   localparam int unsigned PIN_PWR_SRC   = 1;
   localparam int unsigned PIN_CLK_EN    = 7;
   localparam int unsigned PIN_CHRDY     = 8;
   localparam int unsigned PIN_MDM_RST   = 9;
   localparam int unsigned PIN_RING      = 10;
   localparam int unsigned PIN_IRQ       = 11;
   localparam int unsigned PIN_CSM       = 12;
   localparam int unsigned PIN_EE_DI     = 13;
   localparam int unsigned PIN_EE_DO     = 14;
   localparam int unsigned PIN_EE_SK     = 15;
   localparam int unsigned PIN_AUX_CLK   = 16;

   typedef enum logic [1:0] {
      KIND_FLASH  = 2'h0,
      KIND_EEPROM = 2'h1,
      KIND_MODEM  = 2'h2
   } lmp_kind_type;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_SETUP  = 3'h1,
      ST_STROBE = 3'h3,
      ST_HOLD   = 3'h2,
      ST_EE_CS  = 3'h6,
      ST_EE_LO  = 3'h7,
      ST_EE_HI  = 3'h5,
      ST_EE_END = 3'h4
   } lmp_state_type;

   typedef struct packed {
      lmp_kind_type      kind;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        ee_len;
      logic [EE_W-1:0]   ee_wdata;
   } lmp_req_type;

   typedef struct packed {
      logic              done;
      logic [DATA_W-1:0] rdata;
      logic [EE_W-1:0]   ee_rdata;
   } lmp_rsp_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr_o;
      logic [ADDR_W-1:0] addr_oe;
      logic [DATA_W-1:0] data_o;
      logic [DATA_W-1:0] data_oe;
      logic              ctl_oe;
      logic              serial_rom_select;
      logic              flash_select_n;
      logic              local_read_strobe_n;
      logic              local_write_strobe_n;
   } lmp_pins_type;

   localparam lmp_pins_type PINS_RESET = '{
      addr_o: '0, addr_oe: '0, data_o: '0, data_oe: '0, ctl_oe: 1'b0,
      serial_rom_select: 1'b0, flash_select_n: 1'b1,
      local_read_strobe_n: 1'b1, local_write_strobe_n: 1'b1};

endpackage : lmp_pkg

// >>> core/lmp_local_memory_port_mux.sv
// Operation
// - Address pin 16 carries 25 MHz clock if clock strap high, else address bit 16.
// - Address pin 7 is strap input during reset, address bit 7 afterwards.
// - Pin 15 is serial ROM shift clock in ROM accesses, else address 15.
// - Pin 14 receives serial ROM data in ROM accesses, else drives address 14.
// - Pin 13 shifts data out to serial ROM in ROM accesses, else address 13.
// - Serial ROM select asserted for the whole of each ROM access.
// - Modem mode: pin 12 open-drain central-site output, low only on request.
// - Modem mode: pin 11 is an input carrying modem interrupt request.
// - Modem mode: pin 10 is an input carrying active-low ring indication.
// - Modem mode: pin 9 drives active-high modem reset.
// - Modem mode: pin 8 is channel-ready input stretching modem accesses.
// - Seventeen address lines reach 128 Kbyte flash; low lines address modem.
// - Pin 1 sampled as power-source strap during reset, address 1 afterwards.
// - Pin 0 sampled as host-type strap during reset, address 0 afterwards.
// - Flash select active in flash accesses; address-enable to modem in modem mode.
// - Active-low read strobe to flash or modem during reads.
// - Active-low write strobe to flash or modem during writes.
// - Eight-bit data bus driven on writes, released on reads.
// - All outputs released and sequencer known while reset asserted.
module lmp_local_memory_port_mux
   import lmp_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              osc_25m,
   input  wire logic              modem_en,
   input  wire logic              modem_reset_req,
   input  wire logic              central_site_req,
   input  wire logic              req_valid,
   input  wire lmp_req_type       req,
   output      logic              req_ready,
   output      lmp_rsp_type       rsp,
   output      logic              clock_out_strap,
   output      logic              power_source_strap,
   output      logic              host_type_strap_n,
   output      logic              modem_irq_in,
   output      logic              modem_ring_n,
   input  wire logic [ADDR_W-1:0] local_address_bus_i,
   input  wire logic [DATA_W-1:0] local_data_bus_i,
   output      lmp_pins_type      pins
);

   localparam logic [CNT_W-1:0] SETUP_LD  = CNT_W'(SETUP_CYC);
   localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC);
   localparam logic [CNT_W-1:0] HOLD_LD   = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] EE_LD     = CNT_W'(EE_HALF_CYC);

   lmp_state_type     state_q;
   lmp_req_type       cmd_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [3:0]        bits_q;
   logic [EE_W-1:0]   ee_sh_q;
   logic [EE_W-1:0]   ee_in_q;
   logic              modem_en_q;
   logic [ADDR_W-1:0] addr_s1_q;
   logic [ADDR_W-1:0] addr_s2_q;
   logic [DATA_W-1:0] data_s1_q;
   logic [DATA_W-1:0] data_s2_q;
   logic              osc_s1_q;
   logic              osc_s2_q;
   logic              cnt_end;
   logic              ee_act;
   logic              par_act;
   lmp_pins_type      pins_d;
   logic              take;
   logic              chrdy_wait;
   logic              strobe_end;
   logic              bit_end;
   logic              acc_end;
   logic [ADDR_W-1:0] addr_o_d;
   logic [ADDR_W-1:0] addr_oe_d;

   ////////////////////////////////////////////////////////////////////////////
   // State decode

   assign cnt_end = (cnt_q == CNT_W'(1));
   assign ee_act  = (state_q == ST_EE_CS) || (state_q == ST_EE_LO) ||
                    (state_q == ST_EE_HI) || (state_q == ST_EE_END);
   assign par_act = (state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                    (state_q == ST_HOLD);
   assign take    = req_valid && req_ready && (state_q == ST_IDLE);
   // Modem access waits on channel ready after the minimum strobe
   assign chrdy_wait = (cmd_q.kind == KIND_MODEM) && modem_en_q &&
                       !addr_s2_q[PIN_CHRDY];
   assign strobe_end = (state_q == ST_STROBE) && cnt_end && !chrdy_wait;
   // One serial bit per high phase
   assign bit_end    = (state_q == ST_EE_HI) && cnt_end;
   // Closing edge of a parallel or serial access
   assign acc_end    = cnt_end &&
                       ((state_q == ST_HOLD) || (state_q == ST_EE_END));

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   // No reset: straps are sampled through these flops while rst is held

   always_ff @(posedge ref_clk) begin
      addr_s1_q <= local_address_bus_i;
      addr_s2_q <= addr_s1_q;
   end

   // Read data crosses in like any pin; the strobe length covers the delay
   always_ff @(posedge ref_clk) begin
      data_s1_q <= local_data_bus_i;
      data_s2_q <= data_s1_q;
   end

   // Only a level is passed on; the pin clock is aliased to the ref_clk grid
   always_ff @(posedge ref_clk) begin
      osc_s1_q <= osc_25m;
      osc_s2_q <= osc_s1_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Straps: plain clocked capture while reset is held, frozen after release

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clock_out_strap    <= addr_s2_q[PIN_CLK_EN];
         power_source_strap <= addr_s2_q[PIN_PWR_SRC];
         host_type_strap_n  <= addr_s2_q[PIN_HOST_TYPE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modem status inputs

   // Interrupt reads as idle outside modem mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         modem_irq_in <= 1'b0;
      end else begin
         modem_irq_in <= modem_en_q & addr_s2_q[PIN_IRQ];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         modem_ring_n <= 1'b1;
      end else begin
         modem_ring_n <= ~modem_en_q | addr_s2_q[PIN_RING];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request acceptance

   // Ready only in idle, and dropped in the cycle after the take
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state_q == ST_IDLE) && !take;
      end
   end

   // Mode may only flip while the pins are quiet
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         modem_en_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         modem_en_q <= modem_en;
      end
   end

   // Held for the whole access so no pin changes mid-cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (take) begin
         cmd_q <= req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (take && req.kind == KIND_EEPROM) begin
                  state_q <= ST_EE_CS;
                  cnt_q   <= EE_LD;
               end else if (take) begin
                  state_q <= ST_SETUP;
                  cnt_q   <= SETUP_LD;
               end
            end
            ST_SETUP: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  state_q <= ST_STROBE;
                  cnt_q   <= STROBE_LD;
               end
            end
            ST_STROBE: begin
               // Counter parks at one while the modem holds the cycle
               if (!cnt_end) begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end else if (strobe_end) begin
                  state_q <= ST_HOLD;
                  cnt_q   <= HOLD_LD;
               end
            end
            ST_HOLD: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_EE_CS: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  state_q <= ST_EE_LO;
                  cnt_q   <= EE_LD;
               end
            end
            ST_EE_LO: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  state_q <= ST_EE_HI;
                  cnt_q   <= EE_LD;
               end
            end
            ST_EE_HI: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  cnt_q   <= EE_LD;
                  state_q <= (bits_q == 4'h0) ? ST_EE_END : ST_EE_LO;
               end
            end
            ST_EE_END: begin
               cnt_q <= cnt_q - CNT_W'(1);
               if (cnt_end) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial ROM shifter

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bits_q  <= '0;
         ee_sh_q <= '0;
         ee_in_q <= '0;
      end else if (take) begin
         bits_q  <= req.ee_len;
         ee_sh_q <= req.ee_wdata;
      end else if (bit_end) begin
         // Sample late in the high phase, after the ROM has driven
         ee_in_q <= {ee_in_q[EE_W-2:0], addr_s2_q[PIN_EE_DO]};
         ee_sh_q <= {ee_sh_q[EE_W-2:0], 1'b0};
         bits_q  <= bits_q - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response

   // Data fields stand until the next access that loads them: rdata on any flash or modem access, ee_rdata on a serial ROM access
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp.done <= acc_end;
         if (strobe_end) begin
            rsp.rdata <= data_s2_q;
         end
         if (acc_end && state_q == ST_EE_END) begin
            rsp.ee_rdata <= ee_in_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address pin functions

   always_comb begin
      addr_o_d  = cmd_q.addr;
      addr_oe_d = '1;
      // Aux clock is the oscillator sampled at ref_clk rate
      addr_o_d[PIN_AUX_CLK] = clock_out_strap ? osc_s2_q
                                              : cmd_q.addr[PIN_AUX_CLK];
      if (ee_act) begin
         // Data from the ROM comes back on pin 14
         addr_o_d[PIN_EE_SK]  = (state_q == ST_EE_HI);
         addr_oe_d[PIN_EE_DO] = 1'b0;
         addr_o_d[PIN_EE_DI]  = ee_sh_q[EE_W-1];
      end
      // Modem pins keep their function between accesses
      if (modem_en_q) begin
         addr_o_d[PIN_CSM]     = 1'b0;
         addr_oe_d[PIN_CSM]    = central_site_req;
         addr_oe_d[PIN_IRQ]    = 1'b0;
         addr_oe_d[PIN_RING]   = 1'b0;
         addr_o_d[PIN_MDM_RST] = modem_reset_req;
         addr_oe_d[PIN_CHRDY]  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobes, selects and data bus

   always_comb begin
      pins_d                   = PINS_RESET;
      pins_d.ctl_oe            = 1'b1;
      pins_d.addr_o            = addr_o_d;
      pins_d.addr_oe           = addr_oe_d;
      pins_d.serial_rom_select = ee_act;
      // Flash select doubles as the modem address enable
      if (par_act) begin
         pins_d.flash_select_n = 1'b0;
         if (cmd_q.write) begin
            pins_d.data_o  = cmd_q.wdata;
            pins_d.data_oe = '1;
         end
         if (state_q == ST_STROBE) begin
            pins_d.local_read_strobe_n  = cmd_q.write;
            pins_d.local_write_strobe_n = ~cmd_q.write;
         end
      end
   end

   // Registered so every pin leaves straight from a flop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pins <= PINS_RESET;
      end else begin
         pins <= pins_d;
      end
   end

endmodule : lmp_local_memory_port_mux

// >>> tb/lmp_far_side.sv
module lmp_far_side
   import lmp_pkg::*;
#(
   parameter logic [EE_W-1:0] ROM_WORD = 16'h0000
)
(
   input  wire logic              ref_clk,
   input  wire lmp_pins_type      pins,
   input  wire logic [2:0]        straps,
   input  wire logic              irq,
   input  wire logic              ring_n,
   input  wire logic [4:0]        wait_cyc,
   output      logic [ADDR_W-1:0] addr_in,
   output      logic [DATA_W-1:0] data_in,
   output      logic [EE_W-1:0]   ee_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] last_q = '0;
   logic [EE_W-1:0]   rom_q = '0;
   logic              bit_q = 1'b0;
   logic [4:0]        cnt_q = '0;
   wire sel = !pins.flash_select_n;
   wire strb = sel & !(pins.local_read_strobe_n & pins.local_write_strobe_n);
   ////////////////////////////////////////
   // Released lines show the inverse so a stale value cannot pass
   always_comb begin
      addr_in = (pins.addr_oe & pins.addr_o) | (~pins.addr_oe & ~pins.addr_o);
      if (!pins.addr_oe[PIN_CLK_EN]) addr_in[PIN_CLK_EN] = straps[2];
      if (!pins.addr_oe[PIN_PWR_SRC]) addr_in[PIN_PWR_SRC] = straps[1];
      if (!pins.addr_oe[PIN_HOST_TYPE]) addr_in[PIN_HOST_TYPE] = straps[0];
      if (!pins.addr_oe[PIN_CSM]) addr_in[PIN_CSM] = 1'b1;
      if (!pins.addr_oe[PIN_IRQ]) addr_in[PIN_IRQ] = irq;
      if (!pins.addr_oe[PIN_RING]) addr_in[PIN_RING] = ring_n;
      if (!pins.addr_oe[PIN_CHRDY]) addr_in[PIN_CHRDY] = !(strb && cnt_q < wait_cyc);
      if (!pins.addr_oe[PIN_EE_DO] && pins.serial_rom_select) addr_in[PIN_EE_DO] = bit_q;
      if (pins.data_oe == '1) data_in = pins.data_o;
      else if (sel && !pins.local_read_strobe_n) data_in = mem[pins.addr_o[7:0]];
      else data_in = ~last_q;
   end
   always_ff @(posedge ref_clk) begin
      last_q <= data_in;
      cnt_q <= strb ? cnt_q + 5'(cnt_q < wait_cyc) : 5'h00;
   end
   always @(posedge pins.local_write_strobe_n) if (sel) mem[pins.addr_o[7:0]] = data_in;
   always @(posedge pins.serial_rom_select) rom_q = ROM_WORD;
   always @(posedge pins.addr_o[PIN_EE_SK]) begin
      if (pins.serial_rom_select) begin
         ee_rx = {ee_rx[EE_W-2:0], pins.addr_o[PIN_EE_DI]};
         bit_q = rom_q[EE_W-1];
         rom_q = rom_q << 1;
      end
   end
endmodule : lmp_far_side

// >>> tb/lmp_properties.sv
module lmp_properties
   import lmp_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         rst,
   input wire logic         modem_en,
   input wire logic         modem_reset_req,
   input wire logic         central_site_req,
   input wire logic         req_valid,
   input wire lmp_req_type  req,
   input wire logic         req_ready,
   input wire lmp_rsp_type  rsp,
   input wire lmp_pins_type pins
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire take = req_valid & req_ready;
   wire idle_mdm = req_ready & modem_en;
   reset_float_a: assert property (disable iff (1'b0) rst && $past(rst) |-> pins.addr_oe == '0 && !pins.ctl_oe)
      else $error("pins driven in reset");
   no_overlap_a: assert property (pins.serial_rom_select |-> pins.flash_select_n && pins.local_read_strobe_n)
      else $error("rom select overlaps parallel access");
   read_release_a: assert property (!pins.local_read_strobe_n |-> !pins.flash_select_n && pins.data_oe == '0)
      else $error("read strobe with bus driven");
   write_drive_a: assert property (!pins.local_write_strobe_n |-> !pins.flash_select_n && pins.data_oe == '1)
      else $error("write strobe without bus driven");
   take_select_a: assert property (take && req.kind != KIND_EEPROM |=> !req_ready ##1 !pins.flash_select_n)
      else $error("select late after take");
   rom_select_a: assert property (take && req.kind == KIND_EEPROM |=> ##1 pins.serial_rom_select [*8])
      else $error("rom select not held");
   rom_input_a: assert property (pins.serial_rom_select |-> !pins.addr_oe[PIN_EE_DO])
      else $error("rom data pin driven");
   shift_low_a: assert property ($fell(pins.addr_o[PIN_EE_SK]) && pins.serial_rom_select |-> !pins.addr_o[PIN_EE_SK] [*8])
      else $error("shift clock low phase short");
   modem_pins_a: assert property ((idle_mdm && $stable(modem_reset_req)) [*3] |-> pins.addr_oe[PIN_MDM_RST] && pins.addr_o[PIN_MDM_RST] == modem_reset_req && !pins.addr_oe[PIN_CHRDY] && !pins.addr_oe[PIN_RING] && !pins.addr_oe[PIN_IRQ])
      else $error("modem pin directions wrong");
   central_site_a: assert property ((idle_mdm && $stable(central_site_req)) [*3] |-> pins.addr_oe[PIN_CSM] == central_site_req && !(pins.addr_oe[PIN_CSM] && pins.addr_o[PIN_CSM]))
      else $error("central site pin wrong");
   flash_pins_a: assert property ((req_ready && !modem_en) [*3] |-> pins.addr_oe == '1)
      else $error("address pins not driven");
   done_pulse_a: assert property (take && req.kind == KIND_FLASH |-> ##[8:12] rsp.done ##1 !rsp.done)
      else $error("flash access timing wrong");
   cover property ($rose(pins.serial_rom_select));
   cover property (!pins.local_write_strobe_n && !modem_en);
   cover property (modem_en && !pins.local_read_strobe_n);
endmodule : lmp_properties

bind lmp_local_memory_port_mux lmp_properties lmp_properties_inst (
   .ref_clk(ref_clk), .rst(rst), .modem_en(modem_en), .modem_reset_req(modem_reset_req),
   .central_site_req(central_site_req), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .rsp(rsp), .pins(pins));

// >>> tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lmp_pkg::*;
   localparam logic [EE_W-1:0] ROM_WORD = 16'h3c96;
   logic ref_clk = 0, rst = 1, osc_25m = 0, modem_en = 0, req_valid = 0;
   logic modem_reset_req = 0, central_site_req = 0, irq = 0, ring_n = 1, prev;
   logic req_ready, clock_out_strap, power_source_strap, host_type_strap_n;
   logic modem_irq_in, modem_ring_n;
   lmp_req_type       req = '0;
   lmp_rsp_type       rsp;
   lmp_pins_type      pins;
   logic [ADDR_W-1:0] addr_in, seen;
   logic [DATA_W-1:0] data_in;
   logic [EE_W-1:0]   ee_rx;
   logic [2:0]        straps = 3'h5;
   logic [4:0]        wait_cyc = '0;
   int error_cnt = 0, checks = 0, cyc = 0, lat, n;
   lmp_local_memory_port_mux lmp_local_memory_port_mux_inst (.ref_clk(ref_clk), .rst(rst),
      .osc_25m(osc_25m), .modem_en(modem_en), .modem_reset_req(modem_reset_req),
      .central_site_req(central_site_req), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp(rsp), .clock_out_strap(clock_out_strap),
      .power_source_strap(power_source_strap), .host_type_strap_n(host_type_strap_n),
      .modem_irq_in(modem_irq_in), .modem_ring_n(modem_ring_n),
      .local_address_bus_i(addr_in), .local_data_bus_i(data_in), .pins(pins));
   lmp_far_side #(.ROM_WORD(ROM_WORD)) lmp_far_side_inst (.ref_clk(ref_clk), .pins(pins),
      .straps(straps), .irq(irq), .ring_n(ring_n), .wait_cyc(wait_cyc),
      .addr_in(addr_in), .data_in(data_in), .ee_rx(ee_rx));
   initial forever #12.5 ref_clk = ~ref_clk;
   initial forever #20 osc_25m = ~osc_25m;
   always @(posedge ref_clk) if (++cyc == 8000) begin
      error_cnt++;
      test_done();
   end
   ////////////////////////////////////////
   task automatic chk(input string name, input logic [ADDR_W-1:0] exp, got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Straps need three edges through the sampling flops
   task automatic do_reset(input logic [2:0] s);
      straps = s;
      rst = 1;
      repeat (5) @(posedge ref_clk);
      #1 rst = 0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : do_reset
   task automatic access(input lmp_kind_type k, input logic w, input logic [16:0] a,
                         input logic [7:0] d);
      @(posedge ref_clk);
      #1 req = '{k, w, a, d, 4'hf, 16'ha5c3};
      req_valid = 1;
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      #1 req_valid = 0;
      lat = 0;
      while (rsp.done !== 1'b1 && lat < 3000) begin
         if (pins.flash_select_n === 1'b0) seen = pins.addr_o;
         @(posedge ref_clk);
         #1 lat++;
      end
      chk("done_seen", 1, lat < 3000);
   endtask : access
   task automatic test_done();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial begin
      do_reset(3'h5);
      chk("strap_clk", 1, clock_out_strap);
      chk("strap_pwr", 0, power_source_strap);
      chk("strap_host", 1, host_type_strap_n);
      n = 0;
      repeat (40) begin
         prev = pins.addr_o[PIN_AUX_CLK];
         @(posedge ref_clk);
         #1 n += int'(prev !== pins.addr_o[PIN_AUX_CLK]);
      end
      chk("aux_clock_live", 1, n > 10);
      do_reset(3'h2);
      chk("strap_clk", 0, clock_out_strap);
      chk("strap_pwr", 1, power_source_strap);
      chk("strap_host", 0, host_type_strap_n);
      for (int i = 0; i < 2; i++) begin
         access(KIND_FLASH, 1, i ? 17'h000aa : 17'h10055, 8'h3c ^ 8'(i));
         chk("flash_addr", i ? 17'h000aa : 17'h10055, seen);
      end
      for (int i = 0; i < 2; i++) begin
         access(KIND_FLASH, 0, i ? 17'h000aa : 17'h10055, 8'h00);
         chk("flash_rdata", 8'h3c ^ 8'(i), rsp.rdata);
      end
      access(KIND_EEPROM, 0, '0, '0);
      chk("rom_rdata", ROM_WORD, rsp.ee_rdata);
      chk("rom_wdata", 16'ha5c3, ee_rx);
      modem_en = 1;
      modem_reset_req = 1;
      central_site_req = 1;
      irq = 1;
      ring_n = 0;
      wait_cyc = 5'd12;
      repeat (6) @(posedge ref_clk);
      #1 chk("modem_reset", 1, pins.addr_o[PIN_MDM_RST]);
      chk("csm_low", 2'b10, {pins.addr_oe[PIN_CSM], pins.addr_o[PIN_CSM]});
      chk("modem_irq", 1, modem_irq_in);
      chk("modem_ring", 0, modem_ring_n);
      access(KIND_MODEM, 1, 17'h00003, 8'h5a);
      chk("modem_stretch", 1, lat >= 17);
      access(KIND_MODEM, 0, 17'h00003, 8'h00);
      chk("modem_rdata", 8'h5a, rsp.rdata);
      central_site_req = 0;
      modem_en = 0;
      repeat (6) @(posedge ref_clk);
      #1 chk("modem_irq_off", 0, modem_irq_in);
      chk("ring_off", 1, modem_ring_n);
      chk("addr_oe_all", 17'h1ffff, pins.addr_oe);
      test_done();
   end
endmodule : tb_top
